// ==== shared/smcb_pkg.sv ====
// Constants for the MAC-PHY configuration bit group.
// Assumes a single 125 MHz system clock and an active-low async reset.
package smcb_pkg;
  localparam int CFG_W = 16;
  localparam int POS_THRESH = 10;
  localparam int POS_TX_CT = 9;
  localparam int POS_RX_CT = 8;
  localparam int POS_TS_EN = 7;
  localparam int POS_TS_SIZE = 6;
  localparam int POS_PROT = 5;
  localparam int POS_SEQ_EN = 4;
  localparam logic [CFG_W-1:0] WR_MASK = 16'h0FD0;
  localparam logic [CFG_W-1:0] CFG_RESET = 16'h0000;
  localparam int CREDIT_W = 6;
  localparam logic [CREDIT_W-1:0] THR_1 = 6'h01;
  localparam logic [CREDIT_W-1:0] THR_4 = 6'h04;
  localparam logic [CREDIT_W-1:0] THR_8 = 6'h08;
  localparam logic [CREDIT_W-1:0] THR_16 = 6'h10;
  localparam logic [1:0] TH_ENC_1 = 2'h0;
  localparam logic [1:0] TH_ENC_4 = 2'h1;
  localparam logic [1:0] TH_ENC_8 = 2'h2;
  localparam logic [1:0] TH_ENC_16 = 2'h3;
  typedef enum logic [2:0] {
    SMCB_CAP_WAIT = 3'b001,
    SMCB_CAP_TAKE = 3'b010,
    SMCB_CAP_DONE = 3'b100
  } smcb_cap_t;
endpackage

// ==== design/smcb_seq_mon.sv ====
// Transmit chunk sequence monitor.
// Assumes chunk headers arrive as one-cycle strobes on clk.
`timescale 1ns/1ps
`default_nettype none
module smcb_seq_mon (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Control
  input wire logic seqEn,
  // Chunk header
  input wire logic chunkHdrValid,
  input wire logic chunkSeqBit,
  // Result
  output logic chunkRewrite
);
  logic lastSeq_ff;
  logic seen_ff;
  logic rewrite_ff;

  // Remember the last sequence bit while monitoring
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lastSeq_ff <= 1'b0;
      seen_ff <= 1'b0;
    end else if (!seqEn) begin
      seen_ff <= 1'b0; // RULE_13
    end else if (chunkHdrValid) begin
      lastSeq_ff <= chunkSeqBit;
      seen_ff <= 1'b1;
    end
  end

  // Unchanged sequence bit marks a chunk rewrite
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rewrite_ff <= 1'b0;
    end else begin
      rewrite_ff <= seqEn && chunkHdrValid && seen_ff &&
                    (chunkSeqBit == lastSeq_ff); // RULE_14
    end
  end

  assign chunkRewrite = rewrite_ff;

  property p_no_rewrite_off;
    @(posedge clk) disable iff (!reset_n)
      !seqEn |=> !rewrite_ff;
  endproperty
  a_no_rewrite_off: assert property (p_no_rewrite_off) // RULE_13
    else $error("rewrite flagged while sequence monitoring off");

  property p_rewrite_same;
    @(posedge clk) disable iff (!reset_n)
      (seqEn && chunkHdrValid && seen_ff && chunkSeqBit == lastSeq_ff)
      |=> rewrite_ff;
  endproperty
  a_rewrite_same: assert property (p_rewrite_same) // RULE_14
    else $error("repeated sequence bit not flagged as rewrite");
endmodule // smcb_seq_mon
`default_nettype wire

// ==== design/smcb_config_bits.sv ====
// Configuration bit group: threshold, cut-through, timestamp, protection.
// Assumes a host write port on clk and a protection strap pin.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [RULE_01] Interrupt when credits reach 1, 4, 8
// [RULE_02] Encoding 11 needs sixteen free credits
// [RULE_03] Bit 9 sets transmit cut-through
// [RULE_04] Host feeds cut-through data above 10 Mbps
// [RULE_05] Bit 8 sets receive cut-through
// [RULE_06] Host enables receive cut-through before forwarding
// [RULE_07] Host keeps receive cut-through off in generic
// [RULE_08] Bit 7 gates frame timestamping
// [RULE_09] Bit 6 picks 32 or 64 bit stamps
// [RULE_10] OA protection sends complement with control
// [RULE_11] Generic protection uses CRC8 both directions
// [RULE_12] Protection bit read-only, strapped at power-up
// [RULE_13] Sequence bit ignored when retry disabled
// [RULE_14] Unchanged sequence bit allows chunk rewrite
// [RULE_15] Writable fields reset to zero, read back
module smcb_config_bits (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Host configuration write and read-back
  input wire logic cfgWrite,
  input wire logic [smcb_pkg::CFG_W-1:0] cfgWrData,
  output logic [smcb_pkg::CFG_W-1:0] cfgRdData,
  // Protocol and strap
  input wire logic oaSpiMode,
  input wire logic protStrapPin,
  // Credits and interrupt
  input wire logic [smcb_pkg::CREDIT_W-1:0] tx_free_credits,
  output logic creditIrq,
  // Transmit chunk header
  input wire logic chunkHdrValid,
  input wire logic chunk_sequence_bit,
  output logic chunkRewrite,
  // Mode outputs
  output logic tx_cut_through_en,
  output logic rx_cut_through_en,
  output logic frame_timestamp_en,
  output logic timestamp_size_sel,
  output logic ctrl_protection_en,
  output logic protComplementMode,
  output logic protCrc8Mode,
  output logic chunk_seq_retry_en
);
  import smcb_pkg::*;

  logic [CFG_W-1:0] cfg_ff;
  logic strapS1_ff;
  logic strapS2_ff;
  logic prot_ff;
  smcb_cap_t capState_ff;
  logic irq_ff;
  logic cplMode_ff;
  logic crcMode_ff;
  logic [CFG_W-1:0] rd_ff;
  logic tsSel_ff;

  function automatic logic [CREDIT_W-1:0] thresh(input logic [1:0] enc);
    case (enc)
      TH_ENC_1: thresh = THR_1;
      TH_ENC_4: thresh = THR_4;
      TH_ENC_8: thresh = THR_8;
      default: thresh = THR_16;
    endcase
  endfunction

  // Writable fields
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_ff <= CFG_RESET; // RULE_15
    end else if (cfgWrite) begin
      cfg_ff <= cfgWrData & WR_MASK; // RULE_15
    end
  end

  // Strap synchroniser, free-running so the pin settles during reset
  always_ff @(posedge clk) begin
    strapS1_ff <= protStrapPin;
    strapS2_ff <= strapS1_ff;
  end

  // Strap capture once after reset release
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      capState_ff <= SMCB_CAP_WAIT;
      prot_ff <= 1'b0;
    end else begin
      case (capState_ff)
        SMCB_CAP_WAIT: capState_ff <= SMCB_CAP_TAKE;
        SMCB_CAP_TAKE: begin
          prot_ff <= strapS2_ff; // RULE_12
          capState_ff <= SMCB_CAP_DONE;
        end
        SMCB_CAP_DONE: capState_ff <= SMCB_CAP_DONE;
        default: capState_ff <= SMCB_CAP_WAIT;
      endcase
    end
  end

  // Stamp size gated by stamp enable at write time
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tsSel_ff <= 1'b0;
    end else if (cfgWrite) begin
      tsSel_ff <= cfgWrData[POS_TS_EN] && cfgWrData[POS_TS_SIZE]; // RULE_09
    end
  end

  // Credit threshold interrupt
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= tx_free_credits >=
                thresh(cfg_ff[POS_THRESH+1:POS_THRESH]); // RULE_01 RULE_02
    end
  end

  // Protection scheme per protocol
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cplMode_ff <= 1'b0;
      crcMode_ff <= 1'b0;
    end else begin
      cplMode_ff <= prot_ff && oaSpiMode; // RULE_10
      crcMode_ff <= prot_ff && !oaSpiMode; // RULE_11
    end
  end

  // Read-back with strapped protection bit
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_ff <= CFG_RESET;
    end else begin
      rd_ff <= cfg_ff | ({{(CFG_W-1){1'b0}}, prot_ff} << POS_PROT);
    end
  end

  smcb_seq_mon u_seq (
    .clk(clk),
    .reset_n(reset_n),
    .seqEn(cfg_ff[POS_SEQ_EN] && oaSpiMode), // RULE_13
    .chunkHdrValid(chunkHdrValid),
    .chunkSeqBit(chunk_sequence_bit),
    .chunkRewrite(chunkRewrite)
  );

  assign cfgRdData = rd_ff;
  assign creditIrq = irq_ff;
  assign tx_cut_through_en = cfg_ff[POS_TX_CT]; // RULE_03
  assign rx_cut_through_en = cfg_ff[POS_RX_CT]; // RULE_05
  assign frame_timestamp_en = cfg_ff[POS_TS_EN]; // RULE_08
  assign timestamp_size_sel = tsSel_ff; // RULE_09
  assign ctrl_protection_en = prot_ff;
  assign protComplementMode = cplMode_ff;
  assign protCrc8Mode = crcMode_ff;
  assign chunk_seq_retry_en = cfg_ff[POS_SEQ_EN];

  property p_irq_thresh;
    @(posedge clk) disable iff (!reset_n)
      (tx_free_credits >= thresh(cfg_ff[POS_THRESH+1:POS_THRESH]))
      |=> irq_ff;
  endproperty
  a_irq_thresh: assert property (p_irq_thresh) // RULE_01
    else $error("interrupt missing at credit threshold");

  property p_irq16;
    @(posedge clk) disable iff (!reset_n)
      (cfg_ff[POS_THRESH+1:POS_THRESH] == TH_ENC_16 &&
       tx_free_credits < THR_16) |=> !irq_ff;
  endproperty
  a_irq16: assert property (p_irq16) // RULE_02
    else $error("interrupt below sixteen credits");

  property p_write;
    @(posedge clk) disable iff (!reset_n)
      cfgWrite |=> (tx_cut_through_en == $past(cfgWrData[POS_TX_CT]) &&
                    rx_cut_through_en == $past(cfgWrData[POS_RX_CT]));
  endproperty
  a_write: assert property (p_write) // RULE_03
    else $error("cut-through bits did not take write");

  property p_ts;
    @(posedge clk) disable iff (!reset_n)
      !frame_timestamp_en |-> !timestamp_size_sel;
  endproperty
  a_ts: assert property (p_ts) // RULE_09
    else $error("stamp size active with stamping off");

  property p_prot_const;
    @(posedge clk) disable iff (!reset_n)
      (capState_ff == SMCB_CAP_DONE) |=> $stable(prot_ff);
  endproperty
  a_prot_const: assert property (p_prot_const) // RULE_12
    else $error("protection bit changed after strap capture");

  sequence s_prot_oa_twice;
    (prot_ff && oaSpiMode) ##1 (prot_ff && oaSpiMode);
  endsequence

  property p_prot_mode;
    @(posedge clk) disable iff (!reset_n)
      s_prot_oa_twice |-> cplMode_ff && !crcMode_ff;
  endproperty
  a_prot_mode: assert property (p_prot_mode) // RULE_10
    else $error("complement mode not selected");

  property p_crc_mode;
    @(posedge clk) disable iff (!reset_n)
      (prot_ff && !oaSpiMode) |=> crcMode_ff;
  endproperty
  a_crc_mode: assert property (p_crc_mode) // RULE_11
    else $error("crc8 mode not selected");

  sequence s_wr_then_idle;
    cfgWrite ##1 !cfgWrite;
  endsequence

  property p_readback;
    @(posedge clk) disable iff (!reset_n)
      s_wr_then_idle |=>
        (cfgRdData & WR_MASK) == ($past(cfgWrData, 2) & WR_MASK);
  endproperty
  a_readback: assert property (p_readback) // RULE_15
    else $error("read-back differs from last write");
endmodule // smcb_config_bits
`default_nettype wire

// ==== test/smcb_host_model.sv ====
// SPI host model: issues config writes and tx chunk headers.
// Assumes the bench calls its tasks; drives on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module smcb_host_model (
  // Clock and protocol
  input wire logic clk,
  input wire logic oaSpiMode,
  // Config write
  output logic cfgWrite,
  output logic [smcb_pkg::CFG_W-1:0] cfgWrData,
  // Chunk header
  output logic chunkHdrValid,
  output logic chunk_sequence_bit
);
  import smcb_pkg::*;
  initial begin
    cfgWrite = 1'b0;
    cfgWrData = 16'h0000;
    chunkHdrValid = 1'b0;
    chunk_sequence_bit = 1'b0;
  end
  // Word presented for one cycle, then cfgWrite drops; well above line rate
  task automatic wr(input logic [CFG_W-1:0] d);
    @(negedge clk);
    cfgWrite = 1'b1;
    cfgWrData = oaSpiMode ? d : (d & 16'hFEFF);
    @(negedge clk);
    cfgWrite = 1'b0;
    cfgWrData = ~cfgWrData;
  endtask
  task automatic hdr(input logic s);
    @(negedge clk);
    chunkHdrValid = 1'b1;
    chunk_sequence_bit = s;
    @(negedge clk);
    chunkHdrValid = 1'b0;
    chunk_sequence_bit = ~s;
  endtask
endmodule // smcb_host_model
`default_nettype wire

// ==== test/tb_top.sv ====
// Bench for the configuration bit group.
// Assumes the host model issues writes; bench sets levels on falling edge.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import smcb_pkg::*;
  logic clk, reset_n, oaSpiMode, protStrapPin, creditIrq, chunkRewrite;
  logic cfgWrite, chunkHdrValid, chunk_sequence_bit, seen;
  logic [CFG_W-1:0] cfgWrData, cfgRdData;
  logic [CREDIT_W-1:0] tx_free_credits;
  logic txCt, rxCt, tsEn, tsSize, prot, protCmp, protCrc, seqEn;
  logic [CREDIT_W-1:0] thr [4] = '{THR_1, THR_4, THR_8, THR_16};
  int fail_count = 0;
  int checks_done = 0;
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  smcb_host_model smcb_host_model_i (.clk(clk), .oaSpiMode(oaSpiMode),
    .cfgWrite(cfgWrite), .cfgWrData(cfgWrData),
    .chunkHdrValid(chunkHdrValid), .chunk_sequence_bit(chunk_sequence_bit));
  smcb_config_bits smcb_config_bits_i (.clk(clk), .reset_n(reset_n),
    .cfgWrite(cfgWrite), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData),
    .oaSpiMode(oaSpiMode), .protStrapPin(protStrapPin),
    .tx_free_credits(tx_free_credits), .creditIrq(creditIrq),
    .chunkHdrValid(chunkHdrValid), .chunk_sequence_bit(chunk_sequence_bit),
    .chunkRewrite(chunkRewrite), .tx_cut_through_en(txCt),
    .rx_cut_through_en(rxCt), .frame_timestamp_en(tsEn),
    .timestamp_size_sel(tsSize), .ctrl_protection_en(prot),
    .protComplementMode(protCmp), .protCrc8Mode(protCrc),
    .chunk_seq_retry_en(seqEn));
  task automatic chkW(input logic [CFG_W-1:0] g, input logic [CFG_W-1:0] e);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t word %h expected %h", $time, g, e);
    end
  endtask
  task automatic chkB(input logic g, input logic e);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t flag %b expected %b", $time, g, e);
    end
  endtask
  task automatic waitN(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wrs(input logic [CFG_W-1:0] d);
    smcb_host_model_i.wr(d);
    waitN(2);
  endtask
  task automatic hdrs(input logic s);
    smcb_host_model_i.hdr(s);
    repeat (3) begin
      seen = seen | (chunkRewrite === 1'b1);
      @(negedge clk);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #20000;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    reset_n = 1'b0;
    oaSpiMode = 1'b1;
    protStrapPin = 1'b1;
    tx_free_credits = 6'h00;
    waitN(2);
    reset_n = 1'b1;
    waitN(3);
    chkW(cfgRdData, 16'h0020);
    chkB(protCmp, 1'b1);
    oaSpiMode = 1'b0;
    waitN(3);
    chkB(protCrc, 1'b1);
    chkB(protCmp, 1'b0);
    oaSpiMode = 1'b1;
    $display("test strap done");
    wrs(16'hFFFF);
    chkW(cfgRdData, WR_MASK | 16'h0020);
    chkW({11'h000, txCt, rxCt, tsEn, tsSize, seqEn}, 16'h001F);
    wrs(16'h0000);
    chkW(cfgRdData, 16'h0020);
    chkB(prot, 1'b1);
    wrs(16'h0040);
    chkW({14'h0000, tsEn, tsSize}, 16'h0000);
    $display("test fields done");
    for (int i = 0; i < 4; i++) begin
      wrs({4'h0, 2'(i), 10'h000});
      tx_free_credits = thr[i] - 6'h01;
      waitN(3);
      chkB(creditIrq, 1'b0);
      tx_free_credits = thr[i];
      waitN(3);
      chkB(creditIrq, 1'b1);
    end
    reset_n = 1'b0;
    waitN(1);
    chkB(creditIrq, 1'b0);
    reset_n = 1'b1;
    waitN(3);
    chkW(cfgRdData, 16'h0020);
    $display("test threshold done");
    wrs(16'h0010);
    seen = 1'b0;
    hdrs(1'b0);
    hdrs(1'b1);
    chkB(seen, 1'b0);
    hdrs(1'b1);
    chkB(seen, 1'b1);
    wrs(16'h0000);
    seen = 1'b0;
    hdrs(1'b1);
    hdrs(1'b1);
    chkB(seen, 1'b0);
    oaSpiMode = 1'b0;
    wrs(16'h0110);
    chkB(rxCt, 1'b0);
    seen = 1'b0;
    hdrs(1'b1);
    hdrs(1'b1);
    chkB(seen, 1'b0);
    $display("test chunk done");
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
